// >>> wort_defines.svh
// Constants of the watchdog overflow reset timer: offsets, fields, reset values, timing counts.
`ifndef WORT_DEFINES_SVH
`define WORT_DEFINES_SVH

// Register addresses
`define WORT_ADDR_CSR 16'hffb2
`define WORT_ADDR_CNT 16'hffb3
`define WORT_ADDR_PFS 16'hffc9
`define WORT_ADDR_STOP 16'hfffb
`define WORT_ADDR_IRQ_STAT 16'hffa0
`define WORT_ADDR_IRQ_MASK 16'hffa1

// Control/status field positions
`define WORT_CSR_CWE_INH 7
`define WORT_CSR_CWE 6
`define WORT_CSR_CSRWE_INH 5
`define WORT_CSR_CSRWE 4
`define WORT_CSR_RUN_INH 3
`define WORT_CSR_RUN 2
`define WORT_CSR_FLAG_INH 1
`define WORT_CSR_FLAG 0
`define WORT_STOP_WD_BIT 2
`define WORT_PFS_CLKSEL_BIT 2

// Reset values and fixed-bit masks
`define WORT_CNT_RESET 8'h00
`define WORT_STOP_RESET 8'hff
`define WORT_STOP_FIXED 8'he0
`define WORT_PFS_RESET 8'hd8
`define WORT_PFS_RW_MASK 8'h27
`define WORT_CSR_INH_MASK 8'haa

// Timing
`define WORT_SYS_HZ 100000000
`define WORT_SUB_HZ 32768
`define WORT_SYS_DIV 8192
`define WORT_SUB_PRE 32
`define WORT_RST_HOLD 512

`endif

// >>> wort_pkg.sv
// Types of the watchdog overflow reset timer.
package wort_pkg;

    typedef enum logic [2:0] {
        mode_active,
        mode_sleep,
        mode_watch,
        mode_subactive,
        mode_subsleep,
        mode_standby
    } wort_mode_type;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic pin_lvl;
        logic cwe;
        logic csrwe;
        logic run;
        logic flag;
        logic [7:0] count;
        logic [7:0] stop;
        logic [7:0] pfs;
        logic [12:0] sys_pre;
        logic [11:0] sub_div;
        logic [4:0] sub_pre;
        logic pend;
        logic rst_out;
        logic [8:0] hold;
        logic irq_stat;
        logic irq_mask;
        logic [7:0] rd_data;
    } wort_state_type;

endpackage : wort_pkg

// >>> wort_top.sv
// Watchdog overflow reset timer with register port, chip reset output and interrupt.
`timescale 1ns/10ps
`include "wort_defines.svh"

module wort_top
    import wort_pkg::*;
#(
    parameter int unsigned SYS_DIV = `WORT_SYS_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // External clear pin, active low, asynchronous
    input wire logic external_clear_pin_n,
    // Power mode of the chip
    input wire wort_mode_type power_mode,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Chip reset and interrupt
    output logic chip_reset_out,
    output logic irq
);

    localparam int unsigned SUB_DIV = `WORT_SYS_HZ / `WORT_SUB_HZ;
    localparam logic [12:0] SYS_LAST = 13'(SYS_DIV - 1);
    localparam logic [11:0] SUB_DIV_LAST = 12'(SUB_DIV - 1);
    localparam logic [4:0] SUB_PRE_LAST = 5'(`WORT_SUB_PRE - 1);
    localparam logic [8:0] HOLD_LAST = 9'(`WORT_RST_HOLD - 1);

    wort_state_type s_q;
    wort_state_type s_d;

    logic clk_sel;
    logic stby_eff;
    logic mode_ok;
    logic count_en;
    logic sub_tick_w;
    logic sys_tick;
    logic sub_tick;
    logic inc_tick;
    logic wr_csr;
    logic cnt_wr;
    logic ovf_ev;
    logic pin_clear;
    logic chip_hold;

    ////////////////////////////////////////////////////////////////////////////
    // Count enable and clock sources

    assign clk_sel = s_q.pfs[`WORT_PFS_CLKSEL_BIT];
    assign pin_clear = !s_q.pin_lvl;
    assign chip_hold = s_q.rst_out || pin_clear;
    // Standby bit only bites once run is clear
    assign stby_eff = !s_q.run && !s_q.stop[`WORT_STOP_WD_BIT];
    assign mode_ok = (power_mode == mode_active) || (power_mode == mode_sleep)
        || ((power_mode == mode_subactive) && clk_sel);
    assign count_en = s_q.run && !stby_eff && mode_ok && !chip_hold;
    // Subclock is modelled by a free divider, as the oscillator keeps running
    assign sub_tick_w = (s_q.sub_div == SUB_DIV_LAST);
    assign sys_tick = count_en && !clk_sel && (s_q.sys_pre == SYS_LAST);
    assign sub_tick = count_en && clk_sel && sub_tick_w
        && (s_q.sub_pre == SUB_PRE_LAST);
    assign inc_tick = sys_tick || sub_tick;
    assign wr_csr = reg_wr && (reg_addr == `WORT_ADDR_CSR) && !chip_hold;
    assign cnt_wr = reg_wr && (reg_addr == `WORT_ADDR_CNT) && s_q.cwe && !chip_hold;
    assign ovf_ev = inc_tick && !cnt_wr && (s_q.count == 8'hff);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        // Pin synchroniser; the level moves only when stages two and three agree
        s_d.sync1 = external_clear_pin_n;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        if (s_q.sync2 == s_q.sync3) begin
            s_d.pin_lvl = s_q.sync3;
        end

        s_d.sub_div = sub_tick_w ? 12'h000 : s_q.sub_div + 12'h001;
        // Wrap on the last count, so a short divider still ticks at its own rate
        if (!count_en || sys_tick) begin
            s_d.sys_pre = 13'h0000;
        end else if (!clk_sel) begin
            s_d.sys_pre = s_q.sys_pre + 13'h0001;
        end
        if (count_en && clk_sel) begin
            if (sub_tick_w) begin
                s_d.sub_pre = s_q.sub_pre + 5'h01;
            end
        end else begin
            s_d.sub_pre = 5'h00;
        end

        // Counter: a write wins over a tick in the same cycle
        if (cnt_wr) begin
            s_d.count = reg_wdata;
        end else if (inc_tick) begin
            s_d.count = s_q.count + 8'h01;
        end

        // Control/status writes: each enable moves only if its inhibit is written 0
        if (wr_csr) begin
            if (!reg_wdata[`WORT_CSR_CWE_INH]) begin
                s_d.cwe = reg_wdata[`WORT_CSR_CWE];
            end
            if (!reg_wdata[`WORT_CSR_CSRWE_INH]) begin
                s_d.csrwe = reg_wdata[`WORT_CSR_CSRWE];
            end
            if (s_q.csrwe && !reg_wdata[`WORT_CSR_RUN_INH]) begin
                s_d.run = reg_wdata[`WORT_CSR_RUN];
            end
            if (s_q.csrwe && !reg_wdata[`WORT_CSR_FLAG_INH] && !reg_wdata[`WORT_CSR_FLAG]) begin
                s_d.flag = 1'b0;
            end
        end
        if (reg_wr && (reg_addr == `WORT_ADDR_STOP) && !chip_hold) begin
            s_d.stop = reg_wdata | `WORT_STOP_FIXED;
        end
        if (reg_wr && (reg_addr == `WORT_ADDR_PFS) && !chip_hold) begin
            s_d.pfs = (reg_wdata & `WORT_PFS_RW_MASK) | (`WORT_PFS_RESET & ~`WORT_PFS_RW_MASK);
        end
        if (reg_wr && (reg_addr == `WORT_ADDR_IRQ_MASK)) begin
            s_d.irq_mask = reg_wdata[0];
        end
        if (reg_wr && (reg_addr == `WORT_ADDR_IRQ_STAT) && reg_wdata[0]) begin
            s_d.irq_stat = 1'b0;
        end

        // Overflow: flag and status set after any clear, so the event is never lost
        if (ovf_ev) begin
            s_d.flag = 1'b1;
            s_d.irq_stat = 1'b1;
        end
        s_d.pend = ovf_ev;

        // Chip reset: rises two base cycles after the overflow, held for the full count
        if (s_q.pend) begin
            s_d.rst_out = 1'b1;
            s_d.hold = HOLD_LAST;
        end else if (s_q.rst_out) begin
            if (s_q.hold == 9'h000) begin
                s_d.rst_out = 1'b0;
            end else begin
                s_d.hold = s_q.hold - 9'h001;
            end
        end

        // Chip-wide reset returns this block too, except the irq status and mask; the fired flag survives the reset output but not the clear pin
        if (chip_hold) begin
            s_d.cwe = 1'b0;
            s_d.csrwe = 1'b0;
            s_d.run = 1'b0;
            s_d.count = `WORT_CNT_RESET;
            s_d.stop = `WORT_STOP_RESET;
            s_d.pfs = `WORT_PFS_RESET;
            s_d.pend = 1'b0;
        end
        if (pin_clear) begin
            s_d.flag = 1'b0;
        end

        // Read data stands only in the cycle after the strobe
        s_d.rd_data = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `WORT_ADDR_CSR: begin
                    s_d.rd_data = `WORT_CSR_INH_MASK | {1'b0, s_q.cwe, 1'b0, s_q.csrwe,
                        1'b0, s_q.run, 1'b0, s_q.flag};
                end
                `WORT_ADDR_CNT: begin
                    s_d.rd_data = s_q.count;
                end
                `WORT_ADDR_STOP: begin
                    s_d.rd_data = s_q.stop;
                end
                `WORT_ADDR_PFS: begin
                    s_d.rd_data = s_q.pfs;
                end
                `WORT_ADDR_IRQ_STAT: begin
                    s_d.rd_data = {7'h00, s_q.irq_stat};
                end
                `WORT_ADDR_IRQ_MASK: begin
                    s_d.rd_data = {7'h00, s_q.irq_mask};
                end
                default: begin
                    s_d.rd_data = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{
                sync1: 1'b1, sync2: 1'b1, sync3: 1'b1, pin_lvl: 1'b1,
                cwe: 1'b0, csrwe: 1'b0, run: 1'b0, flag: 1'b0,
                count: `WORT_CNT_RESET, stop: `WORT_STOP_RESET, pfs: `WORT_PFS_RESET,
                sys_pre: 13'h0000, sub_div: 12'h000, sub_pre: 5'h00,
                pend: 1'b0, rst_out: 1'b0, hold: 9'h000,
                irq_stat: 1'b0, irq_mask: 1'b0, rd_data: 8'h00
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rd_data;
    assign chip_reset_out = s_q.rst_out;
    assign irq = s_q.irq_stat && s_q.irq_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [9:0] rst_len_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rst_len_q <= 10'h000;
        end else if (chip_reset_out) begin
            rst_len_q <= rst_len_q + 10'h001;
        end else begin
            rst_len_q <= 10'h000;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_flag_on_ovf;
        ovf_ev && s_q.pin_lvl |=> s_q.flag && s_q.irq_stat;
    endproperty
    a_flag_on_ovf: assert property (p_flag_on_ovf)
        else $error("flag not set on overflow");

    property p_reset_delay;
        ovf_ev |-> !chip_reset_out ##1 !chip_reset_out ##1 chip_reset_out;
    endproperty
    a_reset_delay: assert property (p_reset_delay)
        else $error("chip reset timing wrong");

    property p_reset_len;
        $fell(chip_reset_out) |-> rst_len_q == 10'd512;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("chip reset length wrong");

    property p_reset_clears;
        chip_reset_out |=> s_q.count == 8'h00 && !s_q.run;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("block not reset");

    property p_count_write;
        cnt_wr |=> s_q.count == $past(reg_wdata);
    endproperty
    a_count_write: assert property (p_count_write) else $error("counter write lost");

    property p_count_locked;
        reg_wr && reg_addr == `WORT_ADDR_CNT && !s_q.cwe && !inc_tick && !chip_hold
            |=> $stable(s_q.count);
    endproperty
    a_count_locked: assert property (p_count_locked)
        else $error("locked counter changed");

    property p_increment;
        inc_tick && !cnt_wr |=> s_q.count == $past(s_q.count) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) else $error("counter did not step");

    property p_run_start;
        wr_csr && s_q.csrwe && reg_wdata[3:2] == 2'b01 |=> s_q.run;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run not started");

    property p_csr_locked;
        wr_csr && !s_q.csrwe |=> $stable(s_q.run);
    endproperty
    a_csr_locked: assert property (p_csr_locked)
        else $error("run changed while locked");

    property p_inhibit_read;
        reg_rd && reg_addr == `WORT_ADDR_CSR |=> (reg_rdata & 8'haa) == 8'haa;
    endproperty
    a_inhibit_read: assert property (p_inhibit_read)
        else $error("inhibit bit read zero");

    property p_standby_wait;
        s_q.run && !s_q.stop[2] && mode_ok && !chip_hold |-> count_en;
    endproperty
    a_standby_wait: assert property (p_standby_wait)
        else $error("standby stopped a run");

    property p_mode_halt;
        power_mode == mode_watch || power_mode == mode_subsleep || power_mode == mode_standby
            || (power_mode == mode_subactive && !clk_sel) |-> !inc_tick;
    endproperty
    a_mode_halt: assert property (p_mode_halt) else $error("counted in halted mode");

    property p_clock_source;
        inc_tick |-> (clk_sel ? sub_tick_w : s_q.sys_pre == SYS_LAST);
    endproperty
    a_clock_source: assert property (p_clock_source) else $error("wrong count source");

    property p_pin_clear;
        pin_clear |=> !s_q.flag;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("pin did not clear flag");

    property p_flag_sw_clear;
        wr_csr && s_q.csrwe && reg_wdata[1:0] == 2'b00 && !ovf_ev |=> !s_q.flag;
    endproperty
    a_flag_sw_clear: assert property (p_flag_sw_clear)
        else $error("flag not cleared by guarded write");

    property p_flag_kept;
        s_q.flag && !pin_clear && !(wr_csr && s_q.csrwe && reg_wdata[1:0] == 2'b00)
            |=> s_q.flag;
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("flag lost without a clear");

    property p_flag_hw_only;
        !s_q.flag && !ovf_ev |=> !s_q.flag;
    endproperty
    a_flag_hw_only: assert property (p_flag_hw_only)
        else $error("flag set without overflow");

    property p_run_stop;
        wr_csr && s_q.csrwe && reg_wdata[3:2] == 2'b00 |=> !s_q.run;
    endproperty
    a_run_stop: assert property (p_run_stop)
        else $error("run not cleared");

    property p_count_hold;
        !inc_tick && !cnt_wr && !chip_hold |=> $stable(s_q.count);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter moved without a tick");

    property p_wrap_zero;
        ovf_ev |=> s_q.count == 8'h00;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("counter did not wrap to zero");

    property p_count_read;
        reg_rd && reg_addr == `WORT_ADDR_CNT |=> reg_rdata == $past(s_q.count);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("counter read wrong");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

    property p_reset_blocks;
        chip_reset_out |-> !inc_tick;
    endproperty
    a_reset_blocks: assert property (p_reset_blocks)
        else $error("counted during chip reset");

    property p_standby_idle;
        stby_eff |-> !inc_tick;
    endproperty
    a_standby_idle: assert property (p_standby_idle)
        else $error("counted in module standby");

    c_overflow: cover property (ovf_ev);
    c_reset_done: cover property ($fell(chip_reset_out));
    c_write_vs_tick: cover property (cnt_wr && inc_tick);
    c_sub_count: cover property (sub_tick);
    c_pin_clear: cover property (pin_clear);

endmodule : wort_top

// >>> wort_top_tb_top.sv
// Self-checking testbench of the watchdog overflow reset timer, driven over its register port.
`timescale 1ns/10ps
`include "wort_defines.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end

module wort_top_tb_top;
    import wort_pkg::*;

    // Short prescaler keeps an overflow within a few thousand cycles
    localparam int unsigned SIM_DIV = 16;
    localparam int MAX_CYC = 20000;

    logic clk_sys;
    logic rst;
    logic external_clear_pin_n;
    wort_mode_type power_mode;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic chip_reset_out;
    logic irq;
    int errors;
    int tests_run;
    int cyc;

    wort_top #(.SYS_DIV(SIM_DIV)) i_wort_top (
        .clk_sys(clk_sys),
        .rst(rst),
        .external_clear_pin_n(external_clear_pin_n),
        .power_mode(power_mode),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .chip_reset_out(chip_reset_out),
        .irq(irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // A hang counts as a mismatch and still ends in the report
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            errors++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask : rchk

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask : tdone

    // Does the counter advance over a gap of three prescaler periods?
    task automatic cnt_moves(input logic exp);
        logic [7:0] a;
        logic [7:0] b;
        rd(`WORT_ADDR_CNT, a);
        repeat (3 * SIM_DIV) @(posedge clk_sys);
        rd(`WORT_ADDR_CNT, b);
        `CHK(a !== b, exp)
    endtask : cnt_moves

    // Waits for the chip reset, checks the irq lead cycle and the hold length
    task automatic fire(input logic irq_exp);
        int n;
        int h;
        logic pi;
        n = 0;
        h = 0;
        pi = 1'b0;
        @(posedge clk_sys);
        #1;
        while (chip_reset_out !== 1'b1 && n < 400) begin
            pi = irq;
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK(pi, irq_exp)
        while (chip_reset_out === 1'b1 && h < 600) begin
            @(posedge clk_sys);
            #1;
            h++;
        end
        `CHK(h, 512)
    endtask : fire

    // Control write enable, count write enable, count load, then run
    task automatic arm(input logic [7:0] start);
        wr(`WORT_ADDR_CSR, 8'hdf);
        wr(`WORT_ADDR_CSR, 8'h7f);
        wr(`WORT_ADDR_CNT, start);
        wr(`WORT_ADDR_CSR, 8'hf6);
    endtask : arm

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        tests_run = 0;
        cyc = 0;
        rst = 1'b1;
        external_clear_pin_n = 1'b1;
        power_mode = mode_active;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;

        rchk(`WORT_ADDR_CSR, 8'haa);
        rchk(`WORT_ADDR_CNT, 8'h00);
        rchk(`WORT_ADDR_STOP, 8'hff);
        rchk(`WORT_ADDR_PFS, 8'hd8);
        rchk(16'hff00, 8'h00);
        tdone("reset values");

        wr(`WORT_ADDR_CNT, 8'h55);
        rchk(`WORT_ADDR_CNT, 8'h00);
        wr(`WORT_ADDR_CSR, 8'h7f);
        rchk(`WORT_ADDR_CSR, 8'hea);
        wr(`WORT_ADDR_CNT, 8'h55);
        rchk(`WORT_ADDR_CNT, 8'h55);
        wr(`WORT_ADDR_CSR, 8'hf6);
        rchk(`WORT_ADDR_CSR, 8'hea);
        cnt_moves(1'b0);
        tdone("write guards");

        wr(`WORT_ADDR_IRQ_MASK, 8'h01);
        arm(8'hfd);
        rchk(`WORT_ADDR_CSR, 8'hfe);
        fire(1'b1);
        `CHK(irq, 1'b1)
        rchk(`WORT_ADDR_CSR, 8'hab);
        rchk(`WORT_ADDR_CNT, 8'h00);
        tdone("first overflow");

        wr(`WORT_ADDR_CSR, 8'hfc);
        rchk(`WORT_ADDR_CSR, 8'hab);
        wr(`WORT_ADDR_CSR, 8'hdf);
        wr(`WORT_ADDR_CSR, 8'hfd);
        rchk(`WORT_ADDR_CSR, 8'hbb);
        wr(`WORT_ADDR_CSR, 8'hfc);
        rchk(`WORT_ADDR_CSR, 8'hba);
        wr(`WORT_ADDR_IRQ_STAT, 8'h01);
        @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        tdone("flag and irq clear");

        arm(8'h00);
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_sys);
            power_mode <= wort_mode_type'(m);
            wr(`WORT_ADDR_CNT, 8'h00);
            cnt_moves(m < 2);
            rchk(`WORT_ADDR_CSR, 8'hfe);
        end
        @(posedge clk_sys);
        power_mode <= mode_active;
        wr(`WORT_ADDR_PFS, 8'h04);
        rchk(`WORT_ADDR_PFS, 8'hdc);
        cnt_moves(1'b0);
        wr(`WORT_ADDR_PFS, 8'h00);
        cnt_moves(1'b1);
        tdone("power modes and source");

        wr(`WORT_ADDR_STOP, 8'hfb);
        rchk(`WORT_ADDR_STOP, 8'hfb);
        cnt_moves(1'b1);
        wr(`WORT_ADDR_IRQ_MASK, 8'h00);
        wr(`WORT_ADDR_CNT, 8'hfe);
        fire(1'b0);
        rchk(`WORT_ADDR_CSR, 8'hab);
        rchk(`WORT_ADDR_IRQ_STAT, 8'h01);
        @(posedge clk_sys);
        external_clear_pin_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        external_clear_pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rchk(`WORT_ADDR_CSR, 8'haa);
        tdone("masked overflow and pin clear");

        arm(8'h10);
        cnt_moves(1'b1);
        wr(`WORT_ADDR_CSR, 8'hf2);
        rchk(`WORT_ADDR_CSR, 8'hfa);
        cnt_moves(1'b0);
        wr(`WORT_ADDR_STOP, 8'hfb);
        wr(`WORT_ADDR_CNT, 8'h20);
        cnt_moves(1'b0);
        tdone("stop by software");

        final_report();
    end

endmodule : wort_top_tb_top
